// >>> logger_pkg.sv
// shared constants and types for the mission logger core
package logger_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SEC_NS        = 1_000_000_000;
	localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
	localparam int MIN_SECONDS   = 60;
	localparam int ENTRIES_8BIT  = 8192;
	localparam int ENTRIES_16BIT = 4096;
	localparam logic [4:0]  SP_LAST   = 5'h1F;
	localparam logic [13:0] RATE_MIN  = 14'h0001;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [7:0]  BYTE_ONES = 8'hFF;
	localparam logic [15:0] PW_LO     = 16'h0228;
	localparam logic [15:0] PW_HI     = 16'h0237;
	localparam logic [15:0] REGPG_LO  = 16'h0200;
	localparam logic [15:0] REGPG_HI  = 16'h023F;
	localparam int ES_AA   = 7;
	localparam int ES_ZERO = 6;
	localparam int ES_PF   = 5;
	localparam logic [1:0] RD_TA_LOW  = 2'h0;
	localparam logic [1:0] RD_TA_HIGH = 2'h1;
	localparam logic [1:0] RD_STATUS  = 2'h2;
	localparam logic [1:0] RD_DATA    = 2'h3;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} mem_wr_t;

	typedef struct packed {
		logic        clock_oscillator_enable;
		logic        logging_enable;
		logic        rollover_enable;
		logic        high_speed_sampling;
		logic        start_on_alarm;
		logic        log_16bit;
		logic [13:0] sample_rate;
		logic [15:0] start_delay;
	} mission_cfg_t;

	typedef enum logic [2:0] {
		MS_IDLE  = 3'b000,
		MS_DELAY = 3'b001,
		MS_ARMED = 3'b010,
		MS_STAMP = 3'b011,
		MS_RUN   = 3'b100
	} mission_state_t;

	typedef enum logic [1:0] {
		LG_IDLE = 2'b00,
		LG_MSB  = 2'b01,
		LG_LSB  = 2'b10
	} log_state_t;
endpackage

// >>> mem_model.sv
// log memory stand-in: accepts byte writes, can stall on command
`timescale 1ns/1ps
module mem_model
	import logger_pkg::*;
(
	// clock and reset
	input  wire logic    core_clk_i,
	input  wire logic    nrst_i,
	// write port
	input  wire logic    wr_valid_i,
	input  wire mem_wr_t wr_i,
	output logic         wr_ready_o,
	// stall control
	input  wire logic    stall_i
);
	logic [7:0] mem [0:65535];
	int         wr_cnt;

	// ready only drops when asked, so back-pressure is exercised on purpose
	assign wr_ready_o = !stall_i;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_cnt <= 0;
		end else if (wr_valid_i && wr_ready_o) begin
			mem[wr_i.addr] <= wr_i.data;
			wr_cnt <= wr_cnt + 1;
		end
	end
endmodule

// >>> mission_logger_scratchpad.sv
// mission logging control and scratchpad write/verify/copy path
// Summary of operation
// - log holds 8192 byte or 4096 word entries
// - word entries store high byte at lower address
// - log full: stop, or overwrite when rollover set
// - start needs valid clock, oscillator, clear, logging
// - enabled matching alarm joins conditional search
// - sample rate is 14 bits, 1 to 16383
// - high speed counts seconds, otherwise minutes
// - start sets in-progress, clears memory-cleared flag
// - immediate mode: delay, stamp, log, count both
// - alarm mode: sample, count device counter only
// - alarm sample logged uncounted; stamp next period
// - general memory writable and readable in mission
// - password locations always read as zero
// - status read-only: ending offset, bit6 zero
// - copy only when ending offset is 1Fh
// - incomplete data byte sets partial-byte flag
// - write starts at offset addr[4:0], ends 1Fh
// - accepted copy sets flag; next write clears
// - read gives address low, high, status, data
// - copy auth bytes must match; then copy
// - mission count is 24 bits, cleared by clear
// - mission blocks copy into register pages
`timescale 1ns/1ps
module mission_logger_scratchpad
	import logger_pkg::*;
#(
	parameter int          SEC_CYC  = SEC_CYCLES,
	parameter int          FIFO_DEP = 16,
	parameter logic [15:0] LOG_BASE = 16'h1000
) (
	// clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         nrst_i,
	// mission setup and commands
	input  wire mission_cfg_t cfg_i,
	input  wire logic         rtc_valid_i,
	input  wire logic [31:0]  rtc_now_i,
	input  wire logic         start_mission_i,
	input  wire logic         clear_memory_i,
	// temperature converter
	output logic              conv_req_o,
	input  wire logic         conv_done_i,
	input  wire logic [15:0]  temp_i,
	input  wire logic         alarm_low_i,
	input  wire logic         alarm_high_i,
	input  wire logic         alarm_low_en_i,
	input  wire logic         alarm_high_en_i,
	// scratchpad write
	input  wire logic         sp_wr_start_i,
	input  wire logic [15:0]  sp_wr_ta_i,
	input  wire logic         sp_wr_byte_i,
	input  wire logic [7:0]   sp_wr_data_i,
	input  wire logic         sp_wr_partial_i,
	// scratchpad read and copy
	input  wire logic         sp_rd_start_i,
	input  wire logic         sp_rd_next_i,
	output logic [7:0]        sp_rd_data_o,
	output logic              sp_rd_valid_o,
	input  wire logic         copy_i,
	input  wire logic [23:0]  copy_auth_i,
	output logic              copy_busy_o,
	// memory read filter
	input  wire logic         mem_rd_valid_i,
	input  wire logic [15:0]  mem_rd_addr_i,
	input  wire logic [7:0]   mem_rd_data_i,
	output logic              rd_valid_o,
	output logic [7:0]        rd_data_o,
	// memory write port
	output logic              mem_wr_valid_o,
	output mem_wr_t           mem_wr_o,
	input  wire logic         mem_wr_ready_i,
	// status
	output logic              mission_in_progress_o,
	output logic              memory_cleared_flag_o,
	output logic [23:0]       mission_count_o,
	output logic [23:0]       device_count_o,
	output logic [31:0]       timestamp_o,
	output logic [7:0]        ending_offset_status_o,
	output logic [15:0]       target_address_o,
	output logic              search_match_o
);
	localparam int SCW = $clog2(SEC_CYC);

	mission_state_t ms_ff;
	log_state_t     lg_ff;
	logic [SCW-1:0] sec_cnt_ff;
	logic [5:0]     min_cnt_ff;
	logic           sec_tick;
	logic           min_tick;
	logic           unit_tick;
	logic [15:0]    delay_ff;
	logic [13:0]    rate_cnt_ff;
	logic [13:0]    rate;
	logic           due;
	logic           start_ok;
	logic           clear_ok;
	logic           samp;
	logic           alarm_hit;
	logic           offs_ff;
	logic [23:0]    slot;
	logic           room;
	logic [15:0]    lg_addr_ff;
	logic [7:0]     lg_lsb_ff;
	logic [7:0]     lg_msb_ff;
	logic           lg_word_ff;
	logic           low_flag_ff;
	logic           high_flag_ff;
	logic [7:0]     sp_ff [32];
	logic [4:0]     wptr_ff;
	logic           sp_full_ff;
	logic [4:0]     end_ff;
	logic           pf_ff;
	logic           aa_ff;
	logic [1:0]     rd_ph_ff;
	logic [4:0]     rd_idx_ff;
	logic           rd_done_ff;
	logic [4:0]     cp_idx_ff;
	logic           copy_ok;
	logic           reg_tgt;
	logic           fifo_valid;
	logic           fifo_ready;
	mem_wr_t        fifo_data;
	logic [7:0]     es;

	assign es = {aa_ff, 1'b0, pf_ff, end_ff};

	// time base; stops with the oscillator
	assign sec_tick  = cfg_i.clock_oscillator_enable && (sec_cnt_ff == SCW'(SEC_CYC - 1));
	assign min_tick  = sec_tick && (min_cnt_ff == 6'(MIN_SECONDS - 1));
	assign unit_tick = cfg_i.high_speed_sampling ? sec_tick : min_tick;
	// a zero rate is illegal; it runs as the fastest rate
	assign rate = (cfg_i.sample_rate == '0) ? RATE_MIN : cfg_i.sample_rate;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sec_cnt_ff <= '0;
			min_cnt_ff <= '0;
		end else if (ms_ff == MS_DELAY && delay_ff == '0) begin
			// restart when the start delay ends so the first interval is a whole one
			sec_cnt_ff <= '0;
			min_cnt_ff <= '0;
		end else if (cfg_i.clock_oscillator_enable) begin
			sec_cnt_ff <= sec_tick ? '0 : sec_cnt_ff + 1'b1;
			if (sec_tick) begin
				min_cnt_ff <= min_tick ? '0 : min_cnt_ff + 1'b1;
			end
		end
	end

	assign start_ok = start_mission_i && (ms_ff == MS_IDLE) && memory_cleared_flag_o
		&& cfg_i.logging_enable && cfg_i.clock_oscillator_enable && rtc_valid_i;
	assign clear_ok = clear_memory_i && (ms_ff == MS_IDLE);
	assign due = ((ms_ff == MS_DELAY) && (delay_ff == '0))
		|| ((ms_ff >= MS_ARMED) && unit_tick && (rate_cnt_ff + 14'd1 >= rate));
	assign samp = conv_done_i && (ms_ff >= MS_ARMED);
	assign alarm_hit = (alarm_low_i && alarm_low_en_i) || (alarm_high_i && alarm_high_en_i);
	assign slot = mission_count_o + 24'(offs_ff);
	assign room = cfg_i.rollover_enable
		|| (slot < (cfg_i.log_16bit ? 24'(ENTRIES_16BIT) : 24'(ENTRIES_8BIT)));

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ms_ff                 <= MS_IDLE;
			delay_ff              <= '0;
			rate_cnt_ff           <= '0;
			conv_req_o            <= 1'b0;
			mission_in_progress_o <= 1'b0;
			memory_cleared_flag_o <= 1'b0;
			offs_ff               <= 1'b0;
		end else begin
			conv_req_o <= due;
			if (start_ok) begin
				mission_in_progress_o <= 1'b1;
				memory_cleared_flag_o <= 1'b0;
				delay_ff              <= cfg_i.start_delay;
				offs_ff               <= 1'b0;
				ms_ff                 <= MS_DELAY;
			end else if (clear_ok) begin
				memory_cleared_flag_o <= 1'b1;
			end
			if (ms_ff == MS_DELAY) begin
				if (delay_ff == '0) begin
					rate_cnt_ff <= '0;
					ms_ff       <= cfg_i.start_on_alarm ? MS_ARMED : MS_STAMP;
				end else if (min_tick) begin
					delay_ff <= delay_ff - 1'b1;
				end
			end else if (ms_ff != MS_IDLE && unit_tick) begin
				rate_cnt_ff <= due ? '0 : rate_cnt_ff + 1'b1;
			end
			if (samp && ms_ff == MS_ARMED && alarm_hit) begin
				offs_ff <= 1'b1;
				ms_ff   <= MS_STAMP;
			end else if (samp && ms_ff == MS_STAMP) begin
				ms_ff <= MS_RUN;
			end
		end
	end

	// counters, timestamp and alarm flags
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mission_count_o <= '0;
			device_count_o  <= '0;
			timestamp_o     <= '0;
			low_flag_ff     <= 1'b0;
			high_flag_ff    <= 1'b0;
			search_match_o  <= 1'b0;
		end else begin
			if (clear_ok) begin
				mission_count_o <= '0;
				timestamp_o     <= '0;
				low_flag_ff     <= 1'b0;
				high_flag_ff    <= 1'b0;
			end else if (samp) begin
				low_flag_ff    <= low_flag_ff | alarm_low_i;
				high_flag_ff   <= high_flag_ff | alarm_high_i;
				device_count_o <= device_count_o + 24'd1;
				if (ms_ff == MS_STAMP) begin
					timestamp_o <= rtc_now_i;
				end
				if (ms_ff != MS_ARMED && room) begin
					mission_count_o <= mission_count_o + 24'd1;
				end
			end
			search_match_o <= (low_flag_ff && alarm_low_en_i)
				|| (high_flag_ff && alarm_high_en_i);
		end
	end

	// log entry writer; holds while the fifo is full
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lg_ff      <= LG_IDLE;
			lg_addr_ff <= '0;
			lg_msb_ff  <= '0;
			lg_lsb_ff  <= '0;
			lg_word_ff <= 1'b0;
		end else begin
			case (lg_ff)
				LG_IDLE: begin
					if (samp && room && (ms_ff != MS_ARMED || alarm_hit)) begin
						lg_msb_ff  <= temp_i[15:8];
						lg_lsb_ff  <= temp_i[7:0];
						lg_word_ff <= cfg_i.log_16bit;
						lg_addr_ff <= cfg_i.log_16bit
							? LOG_BASE + {3'b000, slot[11:0], 1'b0}
							: LOG_BASE + {3'b000, slot[12:0]};
						lg_ff      <= LG_MSB;
					end
				end
				LG_MSB: begin
					if (fifo_ready) begin
						lg_ff <= lg_word_ff ? LG_LSB : LG_IDLE;
					end
				end
				LG_LSB: begin
					if (fifo_ready) begin
						lg_ff <= LG_IDLE;
					end
				end
				default: lg_ff <= LG_IDLE;
			endcase
		end
	end

	// scratchpad fill
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			target_address_o <= '0;
			wptr_ff          <= '0;
			sp_full_ff       <= 1'b0;
			end_ff           <= '0;
			pf_ff            <= 1'b0;
		end else if (sp_wr_start_i) begin
			target_address_o <= sp_wr_ta_i;
			wptr_ff          <= sp_wr_ta_i[4:0];
			end_ff           <= sp_wr_ta_i[4:0];
			sp_full_ff       <= 1'b0;
			// a partial byte beside a new start still flags
			pf_ff            <= sp_wr_partial_i;
		end else begin
			if (sp_wr_byte_i && !sp_full_ff) begin
				end_ff     <= wptr_ff;
				sp_full_ff <= (wptr_ff == SP_LAST);
				wptr_ff    <= wptr_ff + 1'b1;
			end
			if (sp_wr_partial_i) begin
				pf_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sp_wr_byte_i && !sp_full_ff && !sp_wr_start_i) begin
			sp_ff[wptr_ff] <= sp_wr_data_i;
		end
	end

	// copy: auth bytes must echo the address registers
	assign reg_tgt = (target_address_o >= REGPG_LO) && (target_address_o <= REGPG_HI);
	assign copy_ok = copy_i && !copy_busy_o && !sp_wr_start_i
		&& (copy_auth_i == {target_address_o[7:0], target_address_o[15:8], es})
		&& (end_ff == SP_LAST)
		&& !(mission_in_progress_o && reg_tgt);

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aa_ff       <= 1'b0;
			copy_busy_o <= 1'b0;
			cp_idx_ff   <= '0;
		end else begin
			if (sp_wr_start_i) begin
				aa_ff <= 1'b0;
			end else if (copy_ok) begin
				aa_ff       <= 1'b1;
				copy_busy_o <= 1'b1;
				cp_idx_ff   <= target_address_o[4:0];
			end
			if (copy_busy_o && lg_ff == LG_IDLE && fifo_ready) begin
				cp_idx_ff <= cp_idx_ff + 1'b1;
				if (cp_idx_ff == end_ff) begin
					copy_busy_o <= 1'b0;
				end
			end
		end
	end

	// internal logging has priority over the copy
	always_comb begin
		fifo_valid = 1'b0;
		fifo_data  = '0;
		if (lg_ff == LG_MSB) begin
			fifo_valid = 1'b1;
			fifo_data  = '{addr: lg_addr_ff, data: lg_msb_ff};
		end else if (lg_ff == LG_LSB) begin
			fifo_valid = 1'b1;
			fifo_data  = '{addr: lg_addr_ff + 16'h0001, data: lg_lsb_ff};
		end else if (copy_busy_o) begin
			fifo_valid = 1'b1;
			fifo_data  = '{addr: {target_address_o[15:5], cp_idx_ff}, data: sp_ff[cp_idx_ff]};
		end
	end

	write_fifo #(
		.WIDTH ($bits(mem_wr_t)),
		.DEPTH (FIFO_DEP)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (fifo_valid),
		.in_data_i   (fifo_data),
		.in_ready_o  (fifo_ready),
		.out_valid_o (mem_wr_valid_o),
		.out_data_o  (mem_wr_o),
		.out_ready_i (mem_wr_ready_i)
	);

	// scratchpad read stream: address, status, then data
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_ph_ff      <= RD_TA_LOW;
			rd_idx_ff     <= '0;
			rd_done_ff    <= 1'b0;
			sp_rd_data_o  <= '0;
			sp_rd_valid_o <= 1'b0;
		end else begin
			sp_rd_valid_o <= sp_rd_next_i && !sp_rd_start_i;
			if (sp_rd_start_i) begin
				rd_ph_ff   <= RD_TA_LOW;
				rd_idx_ff  <= target_address_o[4:0];
				rd_done_ff <= 1'b0;
			end else if (sp_rd_next_i) begin
				case (rd_ph_ff)
					RD_TA_LOW:  sp_rd_data_o <= target_address_o[7:0];
					RD_TA_HIGH: sp_rd_data_o <= target_address_o[15:8];
					RD_STATUS:  sp_rd_data_o <= es;
					default:    sp_rd_data_o <= rd_done_ff ? BYTE_ONES : sp_ff[rd_idx_ff];
				endcase
				if (rd_ph_ff != RD_DATA) begin
					rd_ph_ff <= rd_ph_ff + 1'b1;
				end else if (!rd_done_ff) begin
					rd_done_ff <= (rd_idx_ff == SP_LAST);
					rd_idx_ff  <= rd_idx_ff + 1'b1;
				end
			end
		end
	end

	// memory read filter hides password bytes
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= '0;
		end else begin
			rd_valid_o <= mem_rd_valid_i;
			rd_data_o  <= (mem_rd_addr_i >= PW_LO && mem_rd_addr_i <= PW_HI)
				? BYTE_ZERO : mem_rd_data_i;
		end
	end

	assign ending_offset_status_o = es;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	a_start_sets_mip: assert property (start_ok |=> mission_in_progress_o
		&& !memory_cleared_flag_o) else $error("start did not set in-progress");
	a_start_gated: assert property ($rose(mission_in_progress_o) |->
		$past(memory_cleared_flag_o && cfg_i.logging_enable && rtc_valid_i))
		else $error("mission began without setup");
	a_copy_end_1f: assert property ($rose(aa_ff) |-> $past(end_ff) == SP_LAST)
		else $error("copy accepted with short ending offset");
	a_status_bit6: assert property (!ending_offset_status_o[ES_ZERO])
		else $error("status bit 6 not zero");
	a_pw_read_zero: assert property (mem_rd_valid_i && mem_rd_addr_i >= PW_LO
		&& mem_rd_addr_i <= PW_HI |=> rd_valid_o && rd_data_o == BYTE_ZERO)
		else $error("password byte leaked");
	a_write_clears_aa: assert property (sp_wr_start_i |=> !ending_offset_status_o[ES_AA])
		else $error("write left copy flag set");
	a_reg_copy_block: assert property (copy_i && mission_in_progress_o && reg_tgt
		&& !aa_ff |=> !aa_ff && !copy_busy_o) else $error("register copy during mission");
	a_clear_count: assert property (clear_ok |=> mission_count_o == '0
		&& memory_cleared_flag_o) else $error("clear left count");
	a_alarm_no_count: assert property (samp && ms_ff == MS_ARMED |=>
		mission_count_o == $past(mission_count_o)
		&& device_count_o == $past(device_count_o) + 24'd1)
		else $error("armed sample counted wrongly");
	a_word_order: assert property (lg_ff == LG_MSB && fifo_ready && lg_word_ff |=>
		lg_ff == LG_LSB) else $error("low byte not after high byte");

	c_mission_start: cover property (start_ok ##[1:20] conv_req_o);
	c_copy_done: cover property (copy_ok ##[1:40] !copy_busy_o);
	c_alarm_start: cover property (samp && ms_ff == MS_ARMED && alarm_hit);
	c_word_log: cover property (lg_ff == LG_LSB && fifo_ready);
endmodule

// >>> test_mission_logger_scratchpad.sv
// self-checking bench for the mission logger and scratchpad path
`timescale 1ns/1ps
module test_mission_logger_scratchpad;
	import logger_pkg::*;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
		logic [7:0]  exp;
	} row_t;
	mission_cfg_t cfg_i;
	mem_wr_t      mem_wr_o;
	logic         core_clk_i, nrst_i, rtc_valid_i, start_mission_i, clear_memory_i, conv_req_o;
	logic         conv_done_i, alarm_low_i, alarm_high_i, alarm_low_en_i, alarm_high_en_i;
	logic         sp_wr_start_i, sp_wr_byte_i, sp_wr_partial_i, sp_rd_start_i, sp_rd_next_i;
	logic         sp_rd_valid_o, copy_i, copy_busy_o, mem_rd_valid_i, rd_valid_o, stall;
	logic         mem_wr_valid_o, mem_wr_ready_i, mission_in_progress_o, memory_cleared_flag_o;
	logic         search_match_o;
	logic [7:0]   sp_wr_data_i, sp_rd_data_o, mem_rd_data_i, rd_data_o, ending_offset_status_o;
	logic [15:0]  temp_i, sp_wr_ta_i, mem_rd_addr_i, target_address_o;
	logic [23:0]  copy_auth_i, mission_count_o, device_count_o;
	logic [31:0]  rtc_now_i, timestamp_o;
	int           n_errors, check_count;
	row_t         rows [6] = '{
		'{16'h0227, 8'h5A, 8'h5A}, '{16'h0228, 8'hC3, 8'h00}, '{16'h0230, 8'h7E, 8'h00},
		'{16'h0237, 8'h99, 8'h00}, '{16'h0238, 8'h81, 8'h81}, '{16'h1000, 8'hA5, 8'hA5}
	};
	logic [7:0]   sp_exp [8] = '{8'h3C, 8'h01, 8'h1F, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hFF};

	mission_logger_scratchpad #(.SEC_CYC(10)) u_mission_logger_scratchpad (
		.core_clk_i, .nrst_i, .cfg_i, .rtc_valid_i, .rtc_now_i, .start_mission_i,
		.clear_memory_i, .conv_req_o, .conv_done_i, .temp_i, .alarm_low_i, .alarm_high_i,
		.alarm_low_en_i, .alarm_high_en_i, .sp_wr_start_i, .sp_wr_ta_i, .sp_wr_byte_i,
		.sp_wr_data_i, .sp_wr_partial_i, .sp_rd_start_i, .sp_rd_next_i, .sp_rd_data_o,
		.sp_rd_valid_o, .copy_i, .copy_auth_i, .copy_busy_o, .mem_rd_valid_i, .mem_rd_addr_i,
		.mem_rd_data_i, .rd_valid_o, .rd_data_o, .mem_wr_valid_o, .mem_wr_o, .mem_wr_ready_i,
		.mission_in_progress_o, .memory_cleared_flag_o, .mission_count_o, .device_count_o,
		.timestamp_o, .ending_offset_status_o, .target_address_o, .search_match_o
	);
	mem_model u_mem_model (
		.core_clk_i, .nrst_i, .wr_valid_i(mem_wr_valid_o), .wr_i(mem_wr_o),
		.wr_ready_o(mem_wr_ready_i), .stall_i(stall)
	);

	initial begin
		core_clk_i = 0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	// converter answers one cycle after each request
	always @(posedge core_clk_i) begin
		conv_done_i <= conv_req_o;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	function automatic int level(input int sel);
		return sel ? int'(device_count_o) : u_mem_model.wr_cnt;
	endfunction
	task automatic wait_for(input int sel, input int n);
		for (int k = 0; k < 600 && level(sel) < n; k++)
			tick(1);
		if (level(sel) < n) begin
			n_errors++;
			$display("Error wait %0d expected %0d seen %0d", sel, n, level(sel));
			end_sim();
		end
	endtask
	task automatic do_reset();
		nrst_i = 0;
		tick(4);
		chk("status at reset", ending_offset_status_o, 8'h00);
		chk("flags at reset", {mission_in_progress_o, memory_cleared_flag_o}, 2'b00);
		chk("mission count at reset", mission_count_o, 24'h0);
		nrst_i = 1;
		tick(1);
	endtask
	task automatic pulse_cmd(input logic clr);
		clear_memory_i = clr;
		start_mission_i = !clr;
		tick(1);
		clear_memory_i = 0;
		start_mission_i = 0;
		tick(2);
	endtask
	task automatic filt(input row_t r);
		mem_rd_valid_i = 1;
		mem_rd_addr_i = r.addr;
		mem_rd_data_i = r.data;
		tick(1);
		mem_rd_valid_i = 0;
		for (int k = 0; k < 4 && rd_valid_o !== 1'b1; k++)
			tick(1);
		chk("read filter", {rd_valid_o, rd_data_o}, {1'b1, r.exp});
		tick(1);
	endtask
	task automatic sp_rd(input logic [7:0] exp);
		sp_rd_next_i = 1;
		tick(1);
		sp_rd_next_i = 0;
		for (int k = 0; k < 4 && sp_rd_valid_o !== 1'b1; k++)
			tick(1);
		chk("scratch read", {sp_rd_valid_o, sp_rd_data_o}, {1'b1, exp});
		tick(1);
	endtask
	task automatic sp_write(input logic [15:0] ta, input int n, input logic [7:0] base);
		sp_wr_start_i = 1;
		sp_wr_ta_i = ta;
		tick(1);
		sp_wr_start_i = 0;
		for (int i = 0; i < n; i++) begin
			sp_wr_byte_i = 1;
			sp_wr_data_i = base + 8'(i);
			tick(1);
		end
		sp_wr_byte_i = 0;
	endtask
	task automatic copy(input logic [23:0] auth);
		copy_i = 1;
		copy_auth_i = auth;
		tick(1);
		copy_i = 0;
		tick(2);
	endtask

	initial begin
		{nrst_i, rtc_valid_i, start_mission_i, clear_memory_i, alarm_low_i} = '0;
		{alarm_high_i, alarm_low_en_i, alarm_high_en_i, sp_wr_start_i, sp_wr_byte_i} = '0;
		{sp_wr_partial_i, sp_rd_start_i, sp_rd_next_i, copy_i, mem_rd_valid_i, stall} = '0;
		{sp_wr_data_i, mem_rd_data_i, temp_i, sp_wr_ta_i, mem_rd_addr_i, copy_auth_i} = '0;
		{cfg_i, rtc_now_i} = '0;
		do_reset();
		$display("test reset done");
		foreach (rows[i])
			filt(rows[i]);
		$display("test read filter done");
		// two bytes past the end must be dropped
		sp_write(16'h013C, 6, 8'hA0);
		chk("target", target_address_o, 16'h013C);
		sp_rd_start_i = 1;
		tick(1);
		sp_rd_start_i = 0;
		foreach (sp_exp[i])
			sp_rd(sp_exp[i]);
		copy({8'h3C, 8'h01, 8'h1E});
		chk("status bad auth", ending_offset_status_o, 8'h1F);
		sp_write(16'h013C, 1, 8'h55);
		sp_wr_partial_i = 1;
		tick(1);
		sp_wr_partial_i = 0;
		tick(1);
		chk("status partial", ending_offset_status_o, 8'h3C);
		copy({8'h3C, 8'h01, 8'h3C});
		chk("status short copy", ending_offset_status_o, 8'h3C);
		chk("no copy writes", u_mem_model.wr_cnt, 0);
		$display("test scratchpad done");
		// memory stalled so the buffer fills and refuses
		stall = 1;
		sp_write(16'h0040, 32, 8'h60);
		chk("status full", ending_offset_status_o, 8'h1F);
		copy({8'h40, 8'h00, 8'h1F});
		chk("status copied", ending_offset_status_o, 8'h9F);
		tick(40);
		chk("copy held", {copy_busy_o, 8'(u_mem_model.wr_cnt)}, 9'h100);
		stall = 0;
		wait_for(0, 32);
		for (int i = 0; i < 32; i++)
			chk("copied byte", u_mem_model.mem[16'h0040 + i], 8'h60 + 8'(i));
		chk("copy idle", copy_busy_o, 1'b0);
		sp_write(16'h0040, 0, 8'h00);
		chk("auth cleared", ending_offset_status_o[ES_AA], 1'b0);
		$display("test buffered copy done");
		cfg_i.clock_oscillator_enable = 1;
		cfg_i.high_speed_sampling = 1;
		cfg_i.log_16bit = 1;
		cfg_i.sample_rate = RATE_MIN;
		rtc_valid_i = 1;
		rtc_now_i = 32'h1234_5678;
		temp_i = 16'hBEEF;
		pulse_cmd(1);
		chk("cleared", memory_cleared_flag_o, 1'b1);
		pulse_cmd(0);
		chk("start refused", mission_in_progress_o, 1'b0);
		cfg_i.logging_enable = 1;
		pulse_cmd(0);
		chk("start flags", {mission_in_progress_o, memory_cleared_flag_o}, 2'b10);
		wait_for(0, 34);
		chk("first entry", {u_mem_model.mem[16'h1000], u_mem_model.mem[16'h1001]}, 16'hBEEF);
		chk("stamp", timestamp_o, 32'h1234_5678);
		chk("mission count", mission_count_o, 24'h1);
		chk("device count", device_count_o, 24'h1);
		rtc_now_i = 32'h0BAD_F00D;
		temp_i = 16'h1357;
		wait_for(0, 36);
		chk("second entry", {u_mem_model.mem[16'h1002], u_mem_model.mem[16'h1003]}, 16'h1357);
		chk("stamp held", timestamp_o, 32'h1234_5678);
		sp_write(16'h0200, 32, 8'h10);
		copy({8'h00, 8'h02, 8'h1F});
		chk("register page copy", ending_offset_status_o, 8'h1F);
		sp_write(16'h0100, 32, 8'h20);
		copy({8'h00, 8'h01, 8'h1F});
		chk("general copy in mission", ending_offset_status_o, 8'h9F);
		$display("test immediate mission done");
		do_reset();
		cfg_i.start_on_alarm = 1;
		alarm_high_en_i = 1;
		// low alarm present but disabled must not start logging
		alarm_low_i = 1;
		rtc_now_i = 32'h1234_5678;
		temp_i = 16'h2468;
		pulse_cmd(1);
		pulse_cmd(0);
		wait_for(1, 1);
		tick(2);
		chk("armed mission count", mission_count_o, 24'h0);
		chk("no match yet", search_match_o, 1'b0);
		chk("nothing logged", u_mem_model.wr_cnt, 0);
		alarm_high_i = 1;
		wait_for(0, 2);
		chk("match", search_match_o, 1'b1);
		chk("alarm uncounted", mission_count_o, 24'h0);
		chk("alarm entry", {u_mem_model.mem[16'h1000], u_mem_model.mem[16'h1001]}, 16'h2468);
		alarm_high_i = 0;
		rtc_now_i = 32'h0BAD_F00D;
		temp_i = 16'h9ABC;
		wait_for(1, 3);
		tick(2);
		chk("late stamp", timestamp_o, 32'h0BAD_F00D);
		chk("mission count", mission_count_o, 24'h1);
		wait_for(0, 4);
		chk("next slot", u_mem_model.mem[16'h1002], 8'h9A);
		// byte format from here: one write per entry at base plus slot
		cfg_i.log_16bit = 0;
		temp_i = 16'h7755;
		wait_for(0, 5);
		chk("byte entry", u_mem_model.mem[16'h1002], 8'h77);
		chk("byte entry count", mission_count_o, 24'h2);
		$display("test alarm start done");
		end_sim();
	end
endmodule

// >>> write_fifo.sv
// write fifo with registered output stage
`timescale 1ns/1ps
module write_fifo
	import logger_pkg::*;
#(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             nrst_i,
	// fill side
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	// drain side
	output logic                  out_valid_o,
	output logic [WIDTH-1:0]      out_data_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;

	assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
	assign push       = in_valid_i && in_ready_o;
	// output stage refills whenever empty or consumed
	assign pop        = (cnt_ff != '0) && (!out_valid_o || out_ready_i);

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end else if (pop) begin
			out_valid_o <= 1'b1;
			out_data_o  <= mem_ff[rd_ptr_ff];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end
endmodule
